// file: design/atwr_dev.sv
// Converter end: ready/data output, sleep, calibration and conversion timing
// Function
// - Output idles high, low when result ready
// - Next bit presented each shift clock rise
// - 24-bit two's complement, MSB first
// - Last bit held; 25th pulse returns high
// - Unread result replaced by newer one
// - 26th pulse falling edge starts calibration
// - Host waits for low before clocking
// - Shift clock held high enters sleep; entry only from ST_READY, ST_SHIFT or ST_DONE, not during ST_CAL or ST_CNV
// - Output driven high on sleep entry
// - Clock low wakes, restarts conversion
// - Host sleeps device between single conversions
// - Held 26th pulse: calibrate at wake
// - Power-on reset runs self-calibration
// - Host recalibrates after reference settles
// - Filter reset per conversion in single mode, except a conversion that ends during ST_SHIFT
// - Filter corner at 24% data rate
// - Data rate fixed per variant
// - Internal timing divided from system clock
// - External clock replaces internal oscillator
// - Control only by shift clock timing
// - Calibration plus conversion before ready
// - Wake without calibration: conversion time
`timescale 1ns/1ps
module atwr_dev
  import atwr_pkg::*;
#(
  parameter bit FAST = 1'b1,
  parameter longint CNV_CYC = FAST ? ATWR_CNV_CYC_FAST : ATWR_CNV_CYC_SLOW,
  parameter longint CALCNV_CYC = FAST ? ATWR_CALCNV_CYC_FAST : ATWR_CALCNV_CYC_SLOW,
  parameter longint SLEEP_CYC = ATWR_SLEEP_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Link
  atwr_link_if.dev link,
  // Converter side
  input wire logic [23:0] sample_in,
  input wire logic ext_clk_present,
  input wire logic single_mode,
  output logic filter_reset,
  output logic osc_enable,
  output logic sys_tick,
  output logic sleeping,
  output logic calibrating
);
  import atwr_pkg::*;

  initial begin
    if (CNV_CYC < 1 || CALCNV_CYC <= CNV_CYC || SLEEP_CYC < 1 || SLEEP_CYC >= 32'hFFFFFFFF) begin
      $error("atwr_dev: bad timing parameters");
    end
  end

  typedef enum logic [2:0] {
    ST_CAL, ST_CNV, ST_READY, ST_SHIFT, ST_DONE, ST_SLEEP, ST_SLEEP_CAL
  } atwr_state_t;

  typedef struct packed {
    atwr_state_t st;
    logic [31:0] tmr;
    logic [31:0] hi_cnt;
    logic [23:0] result;
    logic [23:0] shreg;
    logic [4:0] pulses;
    logic sck_q;
    logic dout;
    logic filt_rst;
    logic [7:0] div;
    logic tick;
    logic osc;
    logic slp;
    logic cal;
  } atwr_dev_s_t;

  atwr_dev_s_t s_ff;
  atwr_dev_s_t nxt_s;

  localparam logic [31:0] CNV_N = 32'(CNV_CYC);
  localparam logic [31:0] CAL_N = 32'(CALCNV_CYC);
  localparam logic [31:0] SLP_N = 32'(SLEEP_CYC);
  localparam logic [7:0] DIV_N = 8'(FAST ? ATWR_SYS_DIV_FAST : ATWR_SYS_DIV_SLOW);
  // Filter corner as a share of the data rate; a sinc4 corner sits well under half
  localparam int unsigned CORNER_PCT = ATWR_F3DB_PCT;

  initial begin
    if (CORNER_PCT == 0 || CORNER_PCT >= 50) begin
      $error("atwr_dev: filter corner out of range");
    end
  end

  logic rise;
  logic fall;
  logic sck;
  assign sck = link.shift_clock;
  assign rise = sck & ~s_ff.sck_q;
  assign fall = ~sck & s_ff.sck_q;

  // Next-state logic
  always_comb begin
    nxt_s = s_ff;
    nxt_s.sck_q = sck;
    nxt_s.filt_rst = 1'b0;
    // Internal oscillator off while an external clock is present
    nxt_s.osc = ~ext_clk_present;
    // System tick divided from core clock
    nxt_s.tick = 1'b0;
    if (s_ff.div >= DIV_N - 8'h01) begin
      nxt_s.div = 8'h00;
      nxt_s.tick = 1'b1;
    end else begin
      nxt_s.div = s_ff.div + 8'h01;
    end
    // Held-high counter for sleep detection
    if (sck) begin
      if (s_ff.hi_cnt < SLP_N) begin
        nxt_s.hi_cnt = s_ff.hi_cnt + 32'h1;
      end
    end else begin
      nxt_s.hi_cnt = 32'h0;
    end
    if (s_ff.tmr != 32'h0) begin
      nxt_s.tmr = s_ff.tmr - 32'h1;
    end
    unique case (s_ff.st)
      ST_CAL, ST_CNV: begin
        nxt_s.dout = 1'b1;
        if (s_ff.tmr == 32'h1) begin
          nxt_s.result = sample_in;
          nxt_s.shreg = sample_in;
          nxt_s.dout = 1'b0;
          nxt_s.pulses = 5'h00;
          nxt_s.st = ST_READY;
          nxt_s.filt_rst = single_mode;
          nxt_s.tmr = CNV_N;
        end
      end
      ST_READY, ST_SHIFT, ST_DONE: begin
        if (rise) begin
          // Count stops past the calibration pulse so extra pulses cannot wrap
          if (s_ff.pulses <= 5'(ATWR_CAL_PULSE)) begin
            nxt_s.pulses = s_ff.pulses + 5'h01;
          end
          if (s_ff.pulses < 5'(ATWR_WORD_BITS)) begin
            nxt_s.dout = s_ff.shreg[23];
            nxt_s.shreg = {s_ff.shreg[22:0], 1'b0};
            nxt_s.st = ST_SHIFT;
          end else if (s_ff.pulses == 5'(ATWR_RET_PULSE - 1)) begin
            nxt_s.dout = 1'b1;
            nxt_s.st = ST_DONE;
          end
        end
        if (fall && s_ff.pulses == 5'(ATWR_CAL_PULSE)) begin
          nxt_s.st = ST_CAL;
          nxt_s.dout = 1'b1;
          nxt_s.tmr = CAL_N;
        end else if (s_ff.hi_cnt == SLP_N - 32'h1 && sck) begin
          nxt_s.dout = 1'b1;
          // Held 26th pulse arms calibration at wake
          nxt_s.st = (s_ff.pulses == 5'(ATWR_CAL_PULSE)) ? ST_SLEEP_CAL : ST_SLEEP;
        end else if (s_ff.tmr == 32'h1 && s_ff.st != ST_SHIFT) begin
          // Fresh result overwrites unread one
          nxt_s.result = sample_in;
          nxt_s.shreg = sample_in;
          nxt_s.pulses = 5'h00;
          nxt_s.dout = 1'b0;
          nxt_s.st = ST_READY;
          nxt_s.filt_rst = single_mode;
          nxt_s.tmr = CNV_N;
        end else if (s_ff.tmr == 32'h1) begin
          nxt_s.result = sample_in;
          nxt_s.tmr = CNV_N;
        end
      end
      ST_SLEEP, ST_SLEEP_CAL: begin
        nxt_s.dout = 1'b1;
        if (!sck) begin
          nxt_s.st = (s_ff.st == ST_SLEEP_CAL) ? ST_CAL : ST_CNV;
          nxt_s.tmr = (s_ff.st == ST_SLEEP_CAL) ? CAL_N : CNV_N;
        end
      end
      default: nxt_s.st = ST_CAL;
    endcase
    // Status flags registered from the next state
    nxt_s.slp = (nxt_s.st == ST_SLEEP) || (nxt_s.st == ST_SLEEP_CAL);
    nxt_s.cal = (nxt_s.st == ST_CAL);
  end

  // State register; power-on starts with calibration
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '{st: ST_CAL, tmr: CAL_N, hi_cnt: 32'h0, result: ATWR_RESULT_RST,
                shreg: ATWR_RESULT_RST, pulses: 5'h00, sck_q: 1'b0, dout: 1'b1,
                filt_rst: 1'b0, div: 8'h00, tick: 1'b0, osc: 1'b1, slp: 1'b0,
                cal: 1'b1};
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Outputs straight from state flops
  assign link.ready_data_out = s_ff.dout;
  assign filter_reset = s_ff.filt_rst;
  assign sys_tick = s_ff.tick;
  assign sleeping = s_ff.slp;
  assign calibrating = s_ff.cal;
  assign osc_enable = s_ff.osc;
endmodule

// file: design/atwr_pkg.sv
// Shared constants for the two-wire converter readout link
package atwr_pkg;
  localparam int unsigned ATWR_CLK_HZ = 125000000;
  localparam int unsigned ATWR_WORD_BITS = 24;
  localparam int unsigned ATWR_RET_PULSE = 25;
  localparam int unsigned ATWR_CAL_PULSE = 26;
  localparam logic [23:0] ATWR_RESULT_RST = 24'h000000;
  // System clock figures in Hz for the two variants
  localparam int unsigned ATWR_SYS_HZ_FAST = 2457600;
  localparam int unsigned ATWR_SYS_HZ_SLOW = 2252800;
  // Data rates in millisamples per second
  localparam int unsigned ATWR_ODR_MSPS_FAST = 120000;
  localparam int unsigned ATWR_ODR_MSPS_SLOW = 13750;
  // Filter corner in percent of data rate
  localparam int unsigned ATWR_F3DB_PCT = 24;
  // Times in microseconds
  localparam int unsigned ATWR_CNV_US_FAST = 8600;
  localparam int unsigned ATWR_CNV_US_SLOW = 73000;
  localparam int unsigned ATWR_CALCNV_US_FAST = 208300;
  localparam int unsigned ATWR_CALCNV_US_SLOW = 256100;
  // Sleep detect: shift clock held high this long
  localparam int unsigned ATWR_SLEEP_US = 100;
  // Host shift clock half period in ns
  localparam int unsigned ATWR_HALF_NS = 200;
  localparam int unsigned ATWR_HALF_CYC = (ATWR_HALF_NS * 125) / 1000;
  // Cycle counts from the times at 125 cycles per microsecond (exact, no rounding)
  localparam longint ATWR_CNV_CYC_FAST = longint'(ATWR_CNV_US_FAST) * 125;
  localparam longint ATWR_CNV_CYC_SLOW = longint'(ATWR_CNV_US_SLOW) * 125;
  localparam longint ATWR_CALCNV_CYC_FAST = longint'(ATWR_CALCNV_US_FAST) * 125;
  localparam longint ATWR_CALCNV_CYC_SLOW = longint'(ATWR_CALCNV_US_SLOW) * 125;
  localparam longint ATWR_SLEEP_CYC = longint'(ATWR_SLEEP_US) * 125;
  // System clock divide from 125 MHz
  localparam int unsigned ATWR_SYS_DIV_FAST = ATWR_CLK_HZ / ATWR_SYS_HZ_FAST;
  localparam int unsigned ATWR_SYS_DIV_SLOW = ATWR_CLK_HZ / ATWR_SYS_HZ_SLOW;
endpackage

// file: design/atwr_link_if.sv
// Two-wire link between converter and host
`timescale 1ns/1ps
interface atwr_link_if;
  logic shift_clock;
  logic ready_data_out;
  modport dev (input shift_clock, output ready_data_out);
  modport host (output shift_clock, input ready_data_out);
endinterface

// file: design/atwr_host.sv
// Host end: waits for ready, clocks out word, optional calibrate or sleep
`timescale 1ns/1ps
module atwr_host
  import atwr_pkg::*;
#(
  parameter int unsigned HALF_CYC = ATWR_HALF_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Link
  atwr_link_if.host link,
  // User side
  input wire logic read_req,
  input wire logic [1:0] read_mode,
  input wire logic wake_req,
  output logic [23:0] data_out,
  output logic data_valid,
  output logic busy,
  output logic asleep
);
  import atwr_pkg::*;

  initial begin
    if (HALF_CYC < 1 || HALF_CYC > 255) begin
      $error("atwr_host: HALF_CYC out of range");
    end
  end

  typedef enum logic [2:0] {
    H_IDLE, H_WAIT, H_LOW, H_HIGH, H_HOLD
  } atwr_hstate_t;

  typedef struct packed {
    atwr_hstate_t st;
    logic [7:0] cnt;
    logic [4:0] pulses;
    logic [4:0] target;
    logic hold_end;
    logic sck;
    logic [23:0] shreg;
    logic [23:0] data;
    logic valid;
    logic asleep;
    logic busy;
  } atwr_host_s_t;

  atwr_host_s_t s_ff;
  atwr_host_s_t nxt_s;
  localparam logic [7:0] HALF_N = 8'(HALF_CYC);

  // Modes: 0 read+25th, 1 read+26th cal, 2 read then sleep, 3 read+26th held
  always_comb begin
    nxt_s = s_ff;
    nxt_s.valid = 1'b0;
    unique case (s_ff.st)
      H_IDLE: begin
        if (read_req) begin
          nxt_s.st = H_WAIT;
          nxt_s.pulses = 5'h00;
          nxt_s.target = (read_mode == 2'h1 || read_mode == 2'h3) ?
                         5'(ATWR_CAL_PULSE) : 5'(ATWR_RET_PULSE);
          nxt_s.hold_end = read_mode[1];
        end else if (s_ff.asleep && wake_req) begin
          nxt_s.sck = 1'b0;
          nxt_s.asleep = 1'b0;
        end
      end
      H_WAIT: begin
        if (!link.ready_data_out) begin
          nxt_s.st = H_HIGH;
          nxt_s.sck = 1'b1;
          nxt_s.cnt = HALF_N;
        end
      end
      H_HIGH: begin
        if (s_ff.cnt == 8'h01) begin
          if (s_ff.pulses < 5'(ATWR_WORD_BITS)) begin
            nxt_s.shreg = {s_ff.shreg[22:0], link.ready_data_out};
          end
          nxt_s.pulses = s_ff.pulses + 5'h01;
          if (s_ff.pulses + 5'h01 == s_ff.target && s_ff.hold_end) begin
            nxt_s.st = H_HOLD;
            nxt_s.asleep = 1'b1;
          end else begin
            nxt_s.sck = 1'b0;
            nxt_s.st = H_LOW;
            nxt_s.cnt = HALF_N;
          end
        end else begin
          nxt_s.cnt = s_ff.cnt - 8'h01;
        end
      end
      H_LOW: begin
        if (s_ff.cnt == 8'h01) begin
          if (s_ff.pulses == s_ff.target) begin
            nxt_s.st = H_IDLE;
            nxt_s.data = s_ff.shreg;
            nxt_s.valid = 1'b1;
          end else begin
            nxt_s.sck = 1'b1;
            nxt_s.st = H_HIGH;
            nxt_s.cnt = HALF_N;
          end
        end else begin
          nxt_s.cnt = s_ff.cnt - 8'h01;
        end
      end
      H_HOLD: begin
        nxt_s.st = H_IDLE;
        nxt_s.data = s_ff.shreg;
        nxt_s.valid = 1'b1;
      end
      default: nxt_s.st = H_IDLE;
    endcase
    // Busy flag registered from the next state
    nxt_s.busy = (nxt_s.st != H_IDLE);
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '{st: H_IDLE, cnt: 8'h00, pulses: 5'h00, target: 5'h00, hold_end: 1'b0,
                sck: 1'b0, shreg: 24'h000000, data: 24'h000000, valid: 1'b0,
                asleep: 1'b0, busy: 1'b0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign link.shift_clock = s_ff.sck;
  assign data_out = s_ff.data;
  assign data_valid = s_ff.valid;
  assign busy = s_ff.busy;
  assign asleep = s_ff.asleep;
endmodule

// file: dv/atwr_link_checker.sv
// Assertions on the two-wire link and converter status lines
`timescale 1ns/1ps
module atwr_link_checker #(
  parameter longint CNV_CYC = 200,
  parameter longint CALCNV_CYC = 600,
  parameter longint SLEEP_CYC = 50
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Link
  input wire logic shift_clock,
  input wire logic ready_data_out,
  // Converter status
  input wire logic sleeping,
  input wire logic calibrating,
  input wire logic filter_reset,
  input wire logic single_mode,
  input wire logic ext_clk_present,
  input wire logic osc_enable
);
  localparam int CAL_MAX = int'(CALCNV_CYC) + 8;
  localparam int CNV_MAX = int'(CNV_CYC) + 8;
  localparam int HOLD_MAX = int'(SLEEP_CYC) + 4;
  logic [15:0] hi_cnt_ff;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Cycles the shift clock has been held high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hi_cnt_ff <= 16'h0000;
    end else if (!shift_clock) begin
      hi_cnt_ff <= 16'h0000;
    end else if (hi_cnt_ff != 16'hFFFF) begin
      hi_cnt_ff <= hi_cnt_ff + 16'h0001;
    end
  end
  // Link behaviour
  a_idle_after_reset: assert property ($rose(rst_n) |-> ready_data_out [*8])
    else $error("ready low right after reset");
  a_low_stands: assert property (!shift_clock && !ready_data_out |=> !ready_data_out)
    else $error("ready released without a shift clock rise");
  a_rise_cause: assert property ($rose(ready_data_out) |-> shift_clock || sleeping)
    else $error("output rose with no rise and no sleep");
  a_sleep_high: assert property (sleeping |-> ready_data_out)
    else $error("output low while asleep");
  a_hold_sleeps: assert property (hi_cnt_ff == HOLD_MAX |-> sleeping)
    else $error("held shift clock did not enter sleep");
  a_low_wakes: assert property ($fell(shift_clock) && sleeping |-> ##[1:4] !sleeping)
    else $error("no wake after shift clock low");
  a_cal_quiet: assert property (calibrating |-> ready_data_out)
    else $error("ready low during calibration");
  a_cal_ends_ready: assert property ($rose(calibrating) |-> ##[1:CAL_MAX] !ready_data_out)
    else $error("no ready after calibration");
  a_wake_ready: assert property ($fell(sleeping) && !calibrating |-> ##[1:CNV_MAX] !ready_data_out)
    else $error("no ready after plain wake");
  // Converter side
  a_filter_single: assert property (filter_reset |-> $past(single_mode) ##1 !filter_reset)
    else $error("filter reset outside single mode or too long");
  a_osc_follows: assert property (##1 osc_enable == !$past(ext_clk_present))
    else $error("oscillator enable wrong for clock source");
  // Main scenarios reached
  c_sleep: cover property ($rose(sleeping));
  c_cal: cover property ($rose(calibrating));
  c_filter: cover property (filter_reset);
  c_ready: cover property ($fell(ready_data_out) && !shift_clock);
endmodule

// file: dv/adc_two_wire_readout_ctrl_tb_top.sv
// Bench joining both link ends: reads, calibration, sleep and wake
`timescale 1ns/1ps
module adc_two_wire_readout_ctrl_tb_top;
  localparam longint CNV = 500;
  localparam longint CAL = 900;
  localparam longint SLP = 50;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [23:0] sample_in = 24'hA5C3F1;
  logic ext_clk_present = 1'b0;
  logic single_mode = 1'b1;
  logic read_req = 1'b0;
  logic [1:0] read_mode = 2'h0;
  logic wake_req = 1'b0;
  logic filter_reset, osc_enable, sleeping, calibrating;
  logic [23:0] data_out;
  logic data_valid, busy, asleep;
  logic sys_tick;
  int n_tick = 0;
  int n_filt = 0;
  int err_total = 0;
  int cmp_count = 0;
  atwr_link_if link();
  // Clock of 8 ns period
  always #4 clk = ~clk;
  // Both ends and the checker
  atwr_dev #(.CNV_CYC(CNV), .CALCNV_CYC(CAL), .SLEEP_CYC(SLP)) u_atwr_dev (
    .clk(clk), .rst_n(rst_n), .link(link), .sample_in(sample_in),
    .ext_clk_present(ext_clk_present), .single_mode(single_mode),
    .filter_reset(filter_reset), .osc_enable(osc_enable), .sys_tick(sys_tick),
    .sleeping(sleeping), .calibrating(calibrating));
  atwr_host #(.HALF_CYC(8)) u_atwr_host (
    .clk(clk), .rst_n(rst_n), .link(link), .read_req(read_req), .read_mode(read_mode),
    .wake_req(wake_req), .data_out(data_out), .data_valid(data_valid), .busy(busy),
    .asleep(asleep));
  atwr_link_checker #(.CNV_CYC(CNV), .CALCNV_CYC(CAL), .SLEEP_CYC(SLP)) u_atwr_link_checker (
    .clk(clk), .rst_n(rst_n), .shift_clock(link.shift_clock),
    .ready_data_out(link.ready_data_out), .sleeping(sleeping), .calibrating(calibrating),
    .filter_reset(filter_reset), .single_mode(single_mode),
    .ext_clk_present(ext_clk_present), .osc_enable(osc_enable));
  // Verdict and end of run
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  // Conditions the bench waits on
  function automatic logic seen(input int which);
    case (which)
      0: return link.ready_data_out === 1'b0;
      1: return calibrating === 1'b1;
      2: return sleeping === 1'b1 && asleep === 1'b1;
      3: return busy === 1'b0;
      default: return data_valid === 1'b1;
    endcase
  endfunction
  task automatic wait_for(input int which, input int lim, input string msg);
    int n;
    n = 0;
    while (!seen(which) && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk(seen(which), msg);
    if (!seen(which)) summarize();
  endtask
  // One host read in the given mode
  task automatic do_read(input logic [1:0] mode, input logic [23:0] exp);
    wait_for(3, 2000, "host busy");
    @(negedge clk);
    read_req = 1'b1;
    read_mode = mode;
    @(negedge clk);
    read_req = 1'b0;
    wait_for(4, 5000, "no data word");
    chk(data_out === exp, "data word mismatch");
  endtask
  task automatic wake();
    wait_for(3, 2000, "host busy");
    @(negedge clk);
    wake_req = 1'b1;
    @(negedge clk);
    wake_req = 1'b0;
  endtask
  // Main sequence
  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    repeat (300) @(negedge clk);
    chk(link.ready_data_out === 1'b1, "ready before first result");
    chk(osc_enable === 1'b1, "oscillator off");
    do_read(2'h0, 24'hA5C3F1);
    chk(link.ready_data_out === 1'b1, "no idle high after 25th pulse");
    wait_for(0, 700, "no second result");
    // Unread result is replaced by the next conversion
    sample_in = 24'h3C0F5A;
    repeat (600) @(negedge clk);
    do_read(2'h0, 24'h3C0F5A);
    do_read(2'h1, 24'h3C0F5A);
    wait_for(1, 100, "no calibration");
    wait_for(0, 1000, "no ready after calibration");
    do_read(2'h2, 24'h3C0F5A);
    wait_for(2, 200, "no sleep");
    chk(link.ready_data_out === 1'b1, "ready low in sleep");
    wake();
    wait_for(0, 700, "no ready after wake");
    do_read(2'h3, 24'h3C0F5A);
    wait_for(2, 200, "no sleep before calibration");
    wake();
    wait_for(1, 20, "no calibration at wake");
    wait_for(0, 1000, "no ready after wake calibration");
    chk(filter_reset === 1'b1, "no filter reset in single mode");
    ext_clk_present = 1'b1;
    single_mode = 1'b0;
    repeat (3) @(negedge clk);
    chk(osc_enable === 1'b0, "oscillator still on");
    // Tick rate and no filter reset in continuous mode
    repeat (600) begin
      @(negedge clk);
      if (sys_tick === 1'b1) begin
        n_tick++;
      end
      if (filter_reset === 1'b1) begin
        n_filt++;
      end
    end
    chk(n_tick == 600 / int'(atwr_pkg::ATWR_SYS_DIV_FAST), "system tick rate wrong");
    chk(n_filt == 0, "filter reset in continuous mode");
    summarize();
  end
endmodule
